//--- verilog/olx_pkg.sv
// What this block does
// (RL1) literal OR work register into work register, update negative and zero
// (RL2) opcode 000100da: OR work register with addressed file register
// (RL3) destination bit 0 writes work register, 1 writes file register
// (RL4) bank bit 0 uses access bank, 1 joins bank select register
// (RL5) extended set, bank bit 0, address up to 5fh: indexed offset
// (RL6) pointer load: selector 0..2, high nibble first word, low byte second
// (RL7) copy file register to destination, update negative and zero
// (RL8) two-word file-to-file copy, prefixes 1100 and 1111, flags untouched
// (RL9) file-to-file copy reaches the whole 4096-byte space without bank select
// (RL10) work register may be source or destination of file-to-file copy
// (RL11) program must not copy into program counter or return stack bytes
// (RL12) negative is result bit 7, zero when whole result is zero
`default_nettype none
package olx_pkg;

  localparam int DW  = 8;
  localparam int AW  = 12;
  localparam int IW  = 16;
  localparam int SAW = 4;

  // ****************************************
  // instruction encodings
  // ****************************************
  localparam logic [7:0] OP_OR_LIT    = 8'h09;
  localparam logic [5:0] OP_OR_FILE   = 6'h04;
  localparam logic [5:0] OP_COPY_FILE = 6'h14;
  localparam logic [9:0] OP_PTR_LOAD  = 10'h3b8;
  localparam logic [7:0] OP_PTR_LOW   = 8'hf0;
  localparam logic [3:0] OP_MOVE_SRC  = 4'hc;
  localparam logic [3:0] OP_MOVE_DST  = 4'hf;
  localparam int         POS_DEST     = 9;
  localparam int         POS_BANK     = 8;
  localparam logic [1:0] PTR_COUNT    = 2'h3;

  // ****************************************
  // data space map
  // ****************************************
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
  localparam logic [7:0]  INDEX_LIMIT  = 8'h5f;
  localparam logic [11:0] WORK_ADDR    = 12'hfe8;

  // ****************************************
  // software registers
  // ****************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_BANK   = 4'h1;
  localparam logic [3:0] REG_WORK   = 4'h2;
  localparam logic [3:0] REG_FLAGS  = 4'h3;
  localparam logic [3:0] REG_PTR0L  = 4'h4;
  localparam logic [3:0] REG_PTR0H  = 4'h5;
  localparam logic [3:0] REG_PTR1L  = 4'h6;
  localparam logic [3:0] REG_PTR1H  = 4'h7;
  localparam logic [3:0] REG_PTR2L  = 4'h8;
  localparam logic [3:0] REG_PTR2H  = 4'h9;
  localparam logic [3:0] REG_STATE  = 4'ha;
  localparam logic [3:0] REG_COUNT  = 4'hb;
  localparam int         BIT_EXT    = 0;
  localparam int         BIT_ZERO   = 0;
  localparam int         BIT_NEG    = 1;
  localparam int         BIT_BAD    = 0;
  localparam int         BIT_BUSY   = 1;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [3:0] RST_NIB    = 4'h0;
  localparam logic [7:0] RD_UNMAP   = 8'h00;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } olx_mem_req_t;

  typedef struct packed {
    logic           rd;
    logic           wr;
    logic [SAW-1:0] addr;
    logic [DW-1:0]  wdata;
  } olx_sw_req_t;

  typedef enum logic [2:0] {
    ST_FETCH,
    ST_READ,
    ST_EXEC,
    ST_MOVE_RD,
    ST_MOVE_CAP,
    ST_MOVE2,
    ST_PTR2
  } olx_state_t;

endpackage
`default_nettype wire

//--- verilog/olx_flag_calc.sv
`default_nettype none
module olx_flag_calc
  import olx_pkg::*;
(
  input  wire logic [DW-1:0] result,
  output logic               neg,
  output logic               zero
);

  // ****************************************
  // negative and zero
  // ****************************************
  // (RL12) bit 7, all zero
  assign neg  = result[DW-1];
  assign zero = (result == RST_BYTE);

endmodule
`default_nettype wire

//--- verilog/olx_addr_map.sv
`default_nettype none
module olx_addr_map
  import olx_pkg::*;
(
  input  wire logic [DW-1:0] file_addr,
  input  wire logic          bank_sel,
  input  wire logic [3:0]    bank,
  input  wire logic          ext_en,
  input  wire logic [AW-1:0] index_base,
  output logic [AW-1:0]      data_addr
);

  always_comb begin
    // (RL5) indexed literal offset
    if (!bank_sel && ext_en && (file_addr <= INDEX_LIMIT)) begin
      data_addr = index_base + {4'h0, file_addr};
    // (RL4) bank select joined
    end else if (bank_sel) begin
      data_addr = {bank, file_addr};
    // (RL4) access bank split
    end else if (file_addr < ACCESS_SPLIT) begin
      data_addr = {RST_NIB, file_addr};
    end else begin
      data_addr = {ACCESS_HIGH, file_addr};
    end
  end

endmodule
`default_nettype wire

//--- verilog/olx_core.sv
// The address map and the strobed register port were decided locally.
`default_nettype none
module olx_core
  import olx_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          ce,
  input  wire logic          instr_valid,
  input  wire logic [IW-1:0] instr_word,
  output logic               instr_ready,
  output olx_mem_req_t       mem_req,
  input  wire logic [DW-1:0] mem_rdata,
  input  wire olx_sw_req_t   sw_req,
  output logic [DW-1:0]      sw_rdata
);

  // ****************************************
  // state
  // ****************************************
  olx_state_t    state;
  logic [DW-1:0] wreg;
  logic [3:0]    bank;
  logic          ext_en;
  logic          flag_n;
  logic          flag_z;
  logic          bad_op;
  logic [DW-1:0] retired;
  logic [3:0]    ptr_hi [0:2];
  logic [DW-1:0] ptr_lo [0:2];
  logic [1:0]    ptr_sel;
  logic          op_is_or;
  logic          dest_file;
  logic [AW-1:0] tgt_addr;
  logic [DW-1:0] hold;

  // ****************************************
  // decode
  // ****************************************
  logic          take;
  logic          is_or_lit;
  logic          is_or_file;
  logic          is_copy;
  logic          is_ptr;
  logic          is_move;
  logic          is_second;
  logic          is_ptr_low;
  logic [AW-1:0] mapped_addr;
  logic [AW-1:0] word_addr;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] alu;
  logic          next_n;
  logic          next_z;
  logic          retire;
  logic          sw_wr_flags;

  assign instr_ready = (state == ST_FETCH) || (state == ST_MOVE2) || (state == ST_PTR2);
  assign take        = ce && instr_valid && instr_ready;
  assign is_or_lit   = (instr_word[15:8] == OP_OR_LIT);
  assign is_or_file  = (instr_word[15:10] == OP_OR_FILE);
  assign is_copy     = (instr_word[15:10] == OP_COPY_FILE);
  assign is_ptr      = (instr_word[15:6] == OP_PTR_LOAD) && (instr_word[5:4] != PTR_COUNT);
  assign is_move     = (instr_word[15:12] == OP_MOVE_SRC);
  assign is_second   = (instr_word[15:12] == OP_MOVE_DST);
  assign is_ptr_low  = (instr_word[15:8] == OP_PTR_LOW);
  // (RL9) full 12-bit operand, no bank
  assign word_addr   = instr_word[AW-1:0];
  assign sw_wr_flags = sw_req.wr && (sw_req.addr == REG_FLAGS);

  olx_addr_map u_addr (
    .file_addr  (instr_word[7:0]),
    .bank_sel   (instr_word[POS_BANK]),
    .bank       (bank),
    .ext_en     (ext_en),
    .index_base ({ptr_hi[2], ptr_lo[2]}),
    .data_addr  (mapped_addr)
  );

  // (RL10) work register mapped in the data space
  assign rd_val = (tgt_addr == WORK_ADDR) ? wreg : mem_rdata;

  always_comb begin
    if (state == ST_EXEC) begin
      // (RL2) or with file, (RL7) plain copy
      alu = op_is_or ? (rd_val | wreg) : rd_val;
    end else begin
      // (RL1) literal or
      alu = wreg | instr_word[7:0];
    end
  end

  olx_flag_calc u_flags (
    .result (alu),
    .neg    (next_n),
    .zero   (next_z)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_FETCH;
    end else if (ce) begin
      case (state)
        ST_FETCH: begin
          if (take && (is_or_file || is_copy)) begin
            state <= ST_READ;
          end else if (take && is_ptr) begin
            state <= ST_PTR2;
          end else if (take && is_move) begin
            state <= ST_MOVE_RD;
          end
        end
        ST_READ:     state <= ST_EXEC;
        ST_EXEC:     state <= ST_FETCH;
        ST_MOVE_RD:  state <= ST_MOVE_CAP;
        ST_MOVE_CAP: state <= ST_MOVE2;
        ST_MOVE2: begin
          if (take) begin
            state <= ST_FETCH;
          end
        end
        ST_PTR2: begin
          if (take) begin
            state <= ST_FETCH;
          end
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  // ****************************************
  // latched operands
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      op_is_or  <= 1'b0;
      dest_file <= 1'b0;
      tgt_addr  <= '0;
      ptr_sel   <= 2'h0;
    end else if (ce && take && (state == ST_FETCH)) begin
      op_is_or  <= is_or_file;
      dest_file <= instr_word[POS_DEST];
      ptr_sel   <= instr_word[5:4];
      if (is_move) begin
        tgt_addr <= word_addr;
      end else begin
        tgt_addr <= mapped_addr;
      end
    end
  end

  // source byte must be caught now: read data stand one cycle only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold <= RST_BYTE;
    end else if (ce && (state == ST_MOVE_CAP)) begin
      hold <= rd_val;
    end
  end

  // ****************************************
  // data memory port
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_req <= '0;
    end else if (ce) begin
      mem_req.rd <= 1'b0;
      mem_req.wr <= 1'b0;
      case (state)
        ST_FETCH: begin
          if (take && (is_or_file || is_copy)) begin
            mem_req.addr <= mapped_addr;
            mem_req.rd   <= (mapped_addr != WORK_ADDR);
          end else if (take && is_move) begin
            mem_req.addr <= word_addr;
            mem_req.rd   <= (word_addr != WORK_ADDR);
          end
        end
        ST_EXEC: begin
          // (RL3) destination bit 1 writes the file
          if (dest_file && (tgt_addr != WORK_ADDR)) begin
            mem_req.wr    <= 1'b1;
            mem_req.addr  <= tgt_addr;
            mem_req.wdata <= alu;
          end
        end
        ST_MOVE2: begin
          // (RL8) second word names destination
          if (take && is_second && (word_addr != WORK_ADDR)) begin
            mem_req.wr    <= 1'b1;
            mem_req.addr  <= word_addr;
            mem_req.wdata <= hold;
          end
        end
        default: begin
          mem_req.rd <= 1'b0;
        end
      endcase
    end
  end

  // (RL11) protected bytes are not filtered; the program keeps off them

  // ****************************************
  // working register
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wreg <= RST_BYTE;
    end else if (ce) begin
      if (state == ST_FETCH && take && is_or_lit) begin
        // (RL1) result back into work
        wreg <= alu;
      end else if (state == ST_EXEC && (!dest_file || tgt_addr == WORK_ADDR)) begin
        // (RL3) destination bit 0 writes work
        wreg <= alu;
      end else if (state == ST_MOVE2 && take && is_second && word_addr == WORK_ADDR) begin
        // (RL10) work as copy destination
        wreg <= hold;
      end else if (sw_req.wr && sw_req.addr == REG_WORK) begin
        wreg <= sw_req.wdata;
      end
    end
  end

  // ****************************************
  // negative and zero flags
  // ****************************************
  // hardware update wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end else if (ce) begin
      if ((state == ST_FETCH && take && is_or_lit) || state == ST_EXEC) begin
        // (RL7) copy updates flags too
        flag_n <= next_n;
        flag_z <= next_z;
      end else if (sw_wr_flags) begin
        flag_n <= sw_req.wdata[BIT_NEG];
        flag_z <= sw_req.wdata[BIT_ZERO];
      end
    end
  end

  // ****************************************
  // pointer registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) begin
        ptr_hi[i] <= RST_NIB;
        ptr_lo[i] <= RST_BYTE;
      end
    end else if (ce) begin
      if (state == ST_FETCH && take && is_ptr) begin
        // (RL6) high part from first word
        ptr_hi[instr_word[5:4]] <= instr_word[3:0];
      end else if (state == ST_PTR2 && take && is_ptr_low) begin
        // (RL6) low byte from second word
        ptr_lo[ptr_sel] <= instr_word[7:0];
      end else if (sw_req.wr) begin
        case (sw_req.addr)
          REG_PTR0L: ptr_lo[0] <= sw_req.wdata;
          REG_PTR0H: ptr_hi[0] <= sw_req.wdata[3:0];
          REG_PTR1L: ptr_lo[1] <= sw_req.wdata;
          REG_PTR1H: ptr_hi[1] <= sw_req.wdata[3:0];
          REG_PTR2L: ptr_lo[2] <= sw_req.wdata;
          REG_PTR2H: ptr_hi[2] <= sw_req.wdata[3:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // control and bank select
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_en <= 1'b0;
      bank   <= RST_NIB;
    end else if (ce && sw_req.wr) begin
      if (sw_req.addr == REG_CTRL) begin
        ext_en <= sw_req.wdata[BIT_EXT];
      end
      if (sw_req.addr == REG_BANK) begin
        bank <= sw_req.wdata[3:0];
      end
    end
  end

  // ****************************************
  // bookkeeping
  // ****************************************
  // a word that no handled instruction claims is skipped, not trapped
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bad_op <= 1'b0;
    end else if (ce) begin
      if (take && state == ST_FETCH &&
          !(is_or_lit || is_or_file || is_copy || is_ptr || is_move)) begin
        bad_op <= 1'b1;
      end else if (take && state == ST_MOVE2 && !is_second) begin
        bad_op <= 1'b1;
      end else if (take && state == ST_PTR2 && !is_ptr_low) begin
        bad_op <= 1'b1;
      end else if (sw_req.wr && sw_req.addr == REG_STATE && sw_req.wdata[BIT_BAD]) begin
        bad_op <= 1'b0;
      end
    end
  end

  assign retire = (state == ST_EXEC) ||
                  (take && state == ST_FETCH && is_or_lit) ||
                  (take && state == ST_MOVE2 && is_second) ||
                  (take && state == ST_PTR2 && is_ptr_low);

  // wraps at 256; a software write clears it unless an instruction retires in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      retired <= RST_BYTE;
    end else if (ce) begin
      if (retire) begin
        retired <= retired + 8'h01;
      end else if (sw_req.wr && sw_req.addr == REG_COUNT) begin
        retired <= RST_BYTE;
      end
    end
  end

  // ****************************************
  // software read port
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sw_rdata <= RD_UNMAP;
    end else if (ce) begin
      sw_rdata <= RD_UNMAP;
      if (sw_req.rd) begin
        case (sw_req.addr)
          REG_CTRL:  sw_rdata <= {7'h00, ext_en};
          REG_BANK:  sw_rdata <= {4'h0, bank};
          REG_WORK:  sw_rdata <= wreg;
          REG_FLAGS: sw_rdata <= {6'h00, flag_n, flag_z};
          REG_PTR0L: sw_rdata <= ptr_lo[0];
          REG_PTR0H: sw_rdata <= {4'h0, ptr_hi[0]};
          REG_PTR1L: sw_rdata <= ptr_lo[1];
          REG_PTR1H: sw_rdata <= {4'h0, ptr_hi[1]};
          REG_PTR2L: sw_rdata <= ptr_lo[2];
          REG_PTR2H: sw_rdata <= {4'h0, ptr_hi[2]};
          REG_STATE: sw_rdata <= {6'h00, (state != ST_FETCH), bad_op};
          REG_COUNT: sw_rdata <= retired;
          default:   sw_rdata <= RD_UNMAP;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- sim/olx_core_monitor.sv
`default_nettype none
module olx_core_monitor
  import olx_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          resetn,
  input wire logic          ce,
  input wire logic          instr_valid,
  input wire logic [IW-1:0] instr_word,
  input wire logic          instr_ready,
  input wire olx_mem_req_t  mem_req,
  input wire logic [DW-1:0] mem_rdata,
  input wire olx_sw_req_t   sw_req,
  input wire logic [DW-1:0] sw_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic          take;
  logic          first;
  logic          pend_mv;
  logic          pend_pt;
  logic          ext_q;
  logic [3:0]    bank_q;
  logic [7:0]    f;
  logic [AW-1:0] exp_addr;
  logic          file_ok;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ****************
  // helpers
  // ****************
  assign take     = ce && instr_valid && instr_ready;
  assign first    = take && !pend_mv && !pend_pt;
  assign f        = instr_word[7:0];
  assign exp_addr = instr_word[POS_BANK] ? {bank_q, f} :
                    (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIGH, f};
  // indexed targets skipped: pointer 2 not tracked, address unknown; work-register targets give no read pulse
  assign file_ok  = first && (instr_word[15:10] == OP_OR_FILE ||
                    instr_word[15:10] == OP_COPY_FILE) && exp_addr != WORK_ADDR &&
                    (instr_word[POS_BANK] || !(ext_q && f <= INDEX_LIMIT));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_mv <= 1'b0;
      pend_pt <= 1'b0;
    end else if (take) begin
      pend_mv <= first && instr_word[15:12] == OP_MOVE_SRC;
      pend_pt <= first && instr_word[15:6] == OP_PTR_LOAD && instr_word[5:4] != PTR_COUNT;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_q  <= 1'b0;
      bank_q <= 4'h0;
    end else if (ce && sw_req.wr) begin
      if (sw_req.addr == REG_CTRL) ext_q <= sw_req.wdata[BIT_EXT];
      if (sw_req.addr == REG_BANK) bank_q <= sw_req.wdata[3:0];
    end
  end

  // ****************
  // properties
  // ****************
  property p_lit;
    first && instr_word[15:8] == OP_OR_LIT |=> instr_ready && !mem_req.rd && !mem_req.wr;
  endproperty
  a_lit: assert property (p_lit) else $error("literal or not single cycle");
  property p_busy;
    file_ok |=> !instr_ready [*2] ##1 instr_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("file op timing wrong");
  property p_dest;
    file_ok |-> ##3 mem_req.wr == $past(instr_word[POS_DEST], 3);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");
  property p_addr;
    file_ok |=> mem_req.rd && mem_req.addr == $past(exp_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("file address wrong");
  property p_ptr;
    first && instr_word[15:6] == OP_PTR_LOAD |=> instr_ready && !mem_req.rd && !mem_req.wr;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load touched memory");
  property p_copy;
    file_ok && instr_word[15:10] == OP_COPY_FILE && instr_word[POS_DEST]
      |-> ##3 mem_req.wdata == $past(mem_rdata, 1);
  endproperty
  a_copy: assert property (p_copy) else $error("copy data wrong");
  property p_mv_dst;
    take && pend_mv && instr_word[15:12] == OP_MOVE_DST && instr_word[11:0] != WORK_ADDR
      |=> mem_req.wr && mem_req.addr == $past(instr_word[11:0]);
  endproperty
  a_mv_dst: assert property (p_mv_dst) else $error("move write wrong");
  property p_mv_src;
    first && instr_word[15:12] == OP_MOVE_SRC && instr_word[11:0] != WORK_ADDR
      |=> mem_req.rd && mem_req.addr == $past(instr_word[11:0]);
  endproperty
  a_mv_src: assert property (p_mv_src) else $error("move read wrong");
  property p_rd_pulse;
    mem_req.rd |=> !mem_req.rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
  property p_excl;
    mem_req.wr |-> !mem_req.rd;
  endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  c_file: cover property (file_ok ##3 mem_req.wr);
  c_move: cover property (take && pend_mv);
  c_ptr: cover property (take && pend_pt);
endmodule
`default_nettype wire

//--- sim/olx_data_mem.sv
`default_nettype none
module olx_data_mem
  import olx_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire olx_mem_req_t mem_req,
  output var logic [DW-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DW-1:0] mem [0:4095];

  initial mem_rdata = 8'h00;
  // whole data space
  // data stands one cycle; the inverse afterwards exposes late sampling
  always @(posedge ref_clk) begin
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd) mem_rdata <= mem[mem_req.addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

//--- sim/olx_core_tb_top.sv
`default_nettype none
module olx_core_tb_top
  import olx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic          ref_clk;
  logic          resetn;
  logic          ce;
  logic          instr_valid;
  logic [IW-1:0] instr_word;
  logic          instr_ready;
  olx_mem_req_t  mem_req;
  logic [DW-1:0] mem_rdata;
  olx_sw_req_t   sw_req;
  logic [DW-1:0] sw_rdata;
  int            miscompares;
  int            compares;

  olx_core i_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .sw_req(sw_req), .sw_rdata(sw_rdata));
  olx_data_mem i_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ****************
  // tasks
  // ****************
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    sw_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    sw_req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic sw_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    sw_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    sw_req.rd <= 1'b0;
    @(posedge ref_clk);
    check(what, exp, sw_rdata);
  endtask

  // the write pulse lands in the model at the edge the issue task ends on
  task automatic mchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    check("data memory", exp, i_mem.mem[a]);
  endtask

  // waits for the word to be taken, then for the core to be ready again
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    instr_valid <= 1'b1;
    instr_word  <= w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!instr_ready && n < 20);
    instr_valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!instr_ready && n < 40);
    if (n >= 40) begin
      miscompares++;
      $display("mismatch instr_ready expected 1 seen 0");
      end_of_test();
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************
  // sequence
  // ****************
  initial begin
    miscompares = 0;
    compares    = 0;
    resetn      = 1'b0;
    ce          = 1'b1;
    instr_valid = 1'b0;
    instr_word  = '0;
    sw_req      = '0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 12; a++) sw_rd(4'(a), RST_BYTE, "reset value");
    sw_wr(4'hd, 8'hff);
    sw_rd(4'hd, RD_UNMAP, "unmapped");
    sw_wr(REG_WORK, 8'h9a);
    issue(16'h0935);
    sw_rd(REG_WORK, 8'hbf, "work");
    sw_rd(REG_FLAGS, 8'h02, "flags");
    sw_wr(REG_WORK, 8'h00);
    issue(16'h0900);
    sw_rd(REG_FLAGS, 8'h01, "flags");
    sw_wr(REG_BANK, 8'h03);
    sw_wr(REG_WORK, 8'h91);
    i_mem.mem[12'h391] = 8'h13;
    issue(16'h1391);
    mchk(12'h391, 8'h93);
    sw_rd(REG_WORK, 8'h91, "work");
    i_mem.mem[12'h020] = 8'h13;
    issue(16'h1020);
    sw_rd(REG_WORK, 8'h93, "work");
    mchk(12'h020, 8'h13);
    i_mem.mem[12'hf90] = 8'h00;
    issue(16'h5090);
    sw_rd(REG_WORK, 8'h00, "work");
    sw_rd(REG_FLAGS, 8'h01, "flags");
    i_mem.mem[12'h322] = 8'h80;
    issue(16'h5322);
    mchk(12'h322, 8'h80);
    sw_rd(REG_FLAGS, 8'h02, "flags");
    for (int s = 0; s < 3; s++) begin
      issue({OP_PTR_LOAD, 2'(s), 4'h3});
      sw_rd(REG_PTR0H + 4'(2 * s), 8'h03, "pointer high");
      issue({OP_PTR_LOW, 8'ha0 + 8'(s)});
      sw_rd(REG_PTR0L + 4'(2 * s), 8'ha0 + 8'(s), "pointer low");
    end
    sw_wr(REG_CTRL, 8'h01);
    i_mem.mem[12'h3b2] = 8'h5a;
    issue(16'h5010);
    sw_rd(REG_WORK, 8'h5a, "indexed");
    i_mem.mem[12'h060] = 8'h11;
    issue(16'h5060);
    sw_rd(REG_WORK, 8'h11, "access");
    sw_wr(REG_CTRL, 8'h00);
    issue(16'h0980);
    // destinations kept clear of program counter and stack bytes
    i_mem.mem[12'h000] = 8'h33;
    issue(16'hc000);
    issue(16'hffff);
    mchk(12'hfff, 8'h33);
    issue(16'hc391);
    issue(16'hffe8);
    sw_rd(REG_WORK, 8'h93, "work");
    issue(16'hcfe8);
    issue(16'hf123);
    mchk(12'h123, 8'h93);
    sw_rd(REG_FLAGS, 8'h02, "flags");
    // unknown word is consumed and flagged; writing 1 clears the flag
    issue(16'h0000);
    sw_rd(REG_STATE, 8'h01, "bad word");
    sw_wr(REG_STATE, 8'h01);
    sw_rd(REG_STATE, 8'h00, "bad cleared");
    sw_wr(REG_COUNT, 8'h00);
    issue(16'h0900);
    sw_rd(REG_COUNT, 8'h01, "retired");
    // clock enable low freezes the software write
    ce <= 1'b0;
    sw_wr(REG_WORK, 8'h55);
    ce <= 1'b1;
    sw_rd(REG_WORK, 8'h93, "frozen work");
    // second reset in mid-run
    resetn <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b1;
    sw_rd(REG_WORK, RST_BYTE, "work after reset");
    sw_rd(REG_FLAGS, RST_BYTE, "flags after reset");
    sw_rd(REG_PTR2L, RST_BYTE, "pointer after reset");
    end_of_test();
  end
endmodule

bind olx_core olx_core_monitor i_mon (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
  .mem_req(mem_req), .mem_rdata(mem_rdata), .sw_req(sw_req), .sw_rdata(sw_rdata));
`default_nettype wire
